/* File: hdl/mis_edge_det.sv */
`timescale 1ns/100ps
module mis_edge_det (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// pin and mode
	input wire logic pin_in,
	input wire logic [1:0] edge_mode_in,
	// result
	output logic edge_evt_out
);
	import mis_pkg::*;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic [1:0] settle_q;
	logic primed;
	logic rise;
	logic fall;

	// ****************************************
	// two-stage synchroniser
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// a pin idling high looks like a rise until both sync stages and prev_q hold its level
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev_q <= 1'b0;
			settle_q <= 2'h0;
		end else begin
			prev_q <= sync2_q;
			if (settle_q != SETTLE_CNT) begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	assign primed = (settle_q == SETTLE_CNT);
	assign rise = primed & sync2_q & ~prev_q;
	assign fall = primed & ~sync2_q & prev_q;

	always_comb begin
		case (edge_mode_in)
			EDGE_RISE: edge_evt_out = rise;
			EDGE_FALL: edge_evt_out = fall;
			EDGE_BOTH: edge_evt_out = rise | fall;
			default: edge_evt_out = 1'b0;
		endcase
	end

	AST_EDGE_OFF_SILENT: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		(edge_mode_in == EDGE_OFF) |-> !edge_evt_out)
		else $error("edge event while edge select is off");
endmodule

/* File: hdl/mis_irq_ctrl.sv */
`timescale 1ns/100ps
module mis_irq_ctrl (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// external pins
	input wire logic [mis_pkg::NUM_EXT-1:0] ext_pin_in,
	input wire logic [mis_pkg::NUM_EXT-1:0] ext_pin_is_input_in,
	input wire logic [mis_pkg::NUM_EXT-1:0] pull_high_sel_in,
	output logic [mis_pkg::NUM_EXT-1:0] pull_high_en_out,
	// edge select write
	input wire logic edge_sel_wr_in,
	input wire logic [3:0] edge_sel_data_in,
	output logic [3:0] ext_edge_select_reg_out,
	// global enable
	input wire logic global_irq_en_set_in,
	input wire logic global_irq_en_clr_in,
	output logic global_irq_en_out,
	// per-source enables
	input wire logic [mis_pkg::NUM_EXT-1:0] ext_pin_irq_en_in,
	input wire logic usb_engine_irq_en_in,
	input wire logic setup_token_irq_en_in,
	input wire logic ep0_in_irq_en_in,
	input wire logic ep0_out_irq_en_in,
	input wire logic group_irq_en_in,
	input wire logic serial_if_irq_en_in,
	input wire logic low_volt_irq_en_in,
	input wire logic [mis_pkg::NUM_TMR-1:0] timer_p_match_en_in,
	input wire logic [mis_pkg::NUM_TMR-1:0] timer_a_match_en_in,
	// request flags, software clear and status
	input wire logic [mis_pkg::NUM_SRC-1:0] req_flag_clr_in,
	output logic [mis_pkg::NUM_SRC-1:0] req_flag_out,
	input wire logic [mis_pkg::NUM_TMR-1:0] timer_p_match_clr_in,
	input wire logic [mis_pkg::NUM_TMR-1:0] timer_a_match_clr_in,
	output logic [mis_pkg::NUM_TMR-1:0] timer_p_match_flag_out,
	output logic [mis_pkg::NUM_TMR-1:0] timer_a_match_flag_out,
	// event sources
	input wire logic usb_ep_access_in,
	input wire logic [mis_pkg::EP_W-1:0] usb_ep_num_in,
	input wire logic [1:0] usb_token_kind_in,
	input wire logic serial_if_byte_done_in,
	input wire logic low_voltage_detector_in,
	input wire logic [mis_pkg::NUM_TMR-1:0] timer_p_match_in,
	input wire logic [mis_pkg::NUM_TMR-1:0] timer_a_match_in,
	// cpu core
	input wire logic stack_full_in,
	input wire logic irq_ack_in,
	input wire logic return_from_interrupt_in,
	output logic irq_req_out,
	output logic [mis_pkg::VEC_W-1:0] irq_vector_out
);
	import mis_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [3:0] ext_edge_select_reg_q;
	logic global_irq_en_q;
	logic [NUM_SRC-1:0] req_flag_q;
	logic [NUM_TMR-1:0] timer_p_match_flag_q;
	logic [NUM_TMR-1:0] timer_a_match_flag_q;
	logic irq_req_q;
	logic [VEC_W-1:0] irq_vec_q;
	logic [NUM_EXT-1:0] ext_evt;
	logic lvd_evt;
	logic [NUM_SRC-1:0] set_evt;
	logic [NUM_SRC-1:0] src_en;
	logic [NUM_SRC-1:0] pending;
	logic group_member_set;
	logic group_member_live;
	logic service_hit;
	logic ep0_hit;

	// lowest index wins, so the source numbering is the priority
	function automatic logic [VEC_W-1:0] mis_pick(input logic [NUM_SRC-1:0] req);
		logic [VEC_W-1:0] idx;
		idx = '0;
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			if (req[k]) begin
				idx = VEC_W'(k);
			end
		end
		return idx;
	endfunction

	// ****************************************
	// edge select field
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ext_edge_select_reg_q <= EDGE_SEL_RST;
		end else if (edge_sel_wr_in) begin
			ext_edge_select_reg_q <= edge_sel_data_in;
		end
	end

	// ****************************************
	// pin edge detection
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++) begin : gen_ext
			mis_edge_det u_edge (
				.clk_sys_in(clk_sys_in),
				.reset_n_in(reset_n_in),
				.pin_in(ext_pin_in[g]),
				.edge_mode_in(ext_edge_select_reg_q[2*g+1 -: 2]),
				.edge_evt_out(ext_evt[g])
			);
		end
	endgenerate

	// the detector output is analog-side, so it is synchronised and a rise taken
	mis_edge_det u_lvd (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.pin_in(low_voltage_detector_in),
		.edge_mode_in(EDGE_RISE),
		.edge_evt_out(lvd_evt)
	);

	// pull-high selection is never overridden by interrupt use
	assign pull_high_en_out = pull_high_sel_in;

	// ****************************************
	// set events per source
	// ****************************************
	assign ep0_hit = usb_ep_access_in & (usb_ep_num_in == EP_ZERO);
	assign group_member_set = |{timer_p_match_in, timer_a_match_in};

	always_comb begin
		set_evt = '0;
		// a pin left as output is not an interrupt input
		set_evt[SRC_EXT0] = ext_evt[0] & ext_pin_is_input_in[0];
		set_evt[SRC_EXT1] = ext_evt[1] & ext_pin_is_input_in[1];
		set_evt[SRC_USB] = usb_ep_access_in & (usb_ep_num_in != EP_ZERO);
		set_evt[SRC_SETUP] = ep0_hit & (usb_token_kind_in == TOKEN_SETUP);
		set_evt[SRC_EP0_IN] = ep0_hit & (usb_token_kind_in == TOKEN_IN);
		set_evt[SRC_EP0_OUT] = ep0_hit & (usb_token_kind_in == TOKEN_OUT);
		set_evt[SRC_GROUP] = group_member_set;
		set_evt[SRC_SERIAL] = serial_if_byte_done_in;
		set_evt[SRC_LVD] = lvd_evt;
	end

	// ****************************************
	// enables and pending requests
	// ****************************************
	assign group_member_live = |((timer_p_match_flag_q & timer_p_match_en_in) |
		(timer_a_match_flag_q & timer_a_match_en_in));

	always_comb begin
		src_en = '0;
		src_en[SRC_EXT0] = ext_pin_irq_en_in[0];
		src_en[SRC_EXT1] = ext_pin_irq_en_in[1];
		src_en[SRC_USB] = usb_engine_irq_en_in;
		src_en[SRC_SETUP] = setup_token_irq_en_in;
		src_en[SRC_EP0_IN] = ep0_in_irq_en_in;
		src_en[SRC_EP0_OUT] = ep0_out_irq_en_in;
		src_en[SRC_GROUP] = group_irq_en_in & group_member_live;
		src_en[SRC_SERIAL] = serial_if_irq_en_in;
		src_en[SRC_LVD] = low_volt_irq_en_in;
	end

	// a full stack holds every request off; flags still record
	assign pending = req_flag_q & src_en & {NUM_SRC{global_irq_en_q & ~stack_full_in}};
	assign service_hit = irq_ack_in & irq_req_q;

	// ****************************************
	// request flags
	// ****************************************
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gen_flag
			// set wins over any clear in the same cycle
			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					req_flag_q[g] <= FLAG_RST;
				end else if (set_evt[g]) begin
					req_flag_q[g] <= 1'b1;
				end else if (req_flag_clr_in[g] | (service_hit & (irq_vec_q == VEC_W'(g)))) begin
					req_flag_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// timer member flags
	// ****************************************
	generate
		for (g = 0; g < NUM_TMR; g++) begin : gen_tmr
			// only software clears these; service of the group leaves them
			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					timer_p_match_flag_q[g] <= FLAG_RST;
				end else if (timer_p_match_in[g]) begin
					timer_p_match_flag_q[g] <= 1'b1;
				end else if (timer_p_match_clr_in[g]) begin
					timer_p_match_flag_q[g] <= 1'b0;
				end
			end
			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					timer_a_match_flag_q[g] <= FLAG_RST;
				end else if (timer_a_match_in[g]) begin
					timer_a_match_flag_q[g] <= 1'b1;
				end else if (timer_a_match_clr_in[g]) begin
					timer_a_match_flag_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// global enable
	// ****************************************
	// a set in the service cycle wins, so software may re-arm at once
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			global_irq_en_q <= GIE_RST;
		end else if (return_from_interrupt_in | global_irq_en_set_in) begin
			global_irq_en_q <= 1'b1;
		end else if (service_hit | global_irq_en_clr_in) begin
			global_irq_en_q <= 1'b0;
		end
	end

	// ****************************************
	// vector request to the core
	// ****************************************
	// dropping the request on the acknowledge avoids a stale second call
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_req_q <= 1'b0;
		end else if (service_hit) begin
			irq_req_q <= 1'b0;
		end else begin
			irq_req_q <= |pending;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_vec_q <= '0;
		end else if (!service_hit) begin
			irq_vec_q <= mis_pick(pending);
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign ext_edge_select_reg_out = ext_edge_select_reg_q;
	assign global_irq_en_out = global_irq_en_q;
	assign req_flag_out = req_flag_q;
	assign timer_p_match_flag_out = timer_p_match_flag_q;
	assign timer_a_match_flag_out = timer_a_match_flag_q;
	assign irq_req_out = irq_req_q;
	assign irq_vector_out = irq_vec_q;

	// ****************************************
	// checks
	// ****************************************
	AST_PIN_EDGE_SETS_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		ext_evt[0] && ext_pin_is_input_in[0] |=> req_flag_q[SRC_EXT0])
		else $error("pin edge did not set its flag");

	AST_CALL_NEEDS_ENABLES: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		$rose(irq_req_q) && irq_vec_q == SRC_EXT0 |->
		$past(global_irq_en_q && ext_pin_irq_en_in[0] && !stack_full_in && req_flag_q[SRC_EXT0]))
		else $error("pin call without enables");

	AST_PIN_SERVICE_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		service_hit && irq_vec_q == SRC_EXT1 && !set_evt[SRC_EXT1] && !global_irq_en_set_in &&
		!return_from_interrupt_in |=> !req_flag_q[SRC_EXT1] && !global_irq_en_q)
		else $error("pin service did not clear flag and global enable");

	AST_USB_OTHER_EP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		usb_ep_access_in && usb_ep_num_in != EP_ZERO |=> req_flag_q[SRC_USB])
		else $error("usb engine flag not set");

	AST_SETUP_TOKEN: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		ep0_hit && usb_token_kind_in == TOKEN_SETUP |=> req_flag_q[SRC_SETUP] && !$past(set_evt[SRC_USB]))
		else $error("setup token flag not set");

	AST_USB_SERVICE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		service_hit && irq_vec_q == SRC_EP0_OUT && !set_evt[SRC_EP0_OUT] |=> !req_flag_q[SRC_EP0_OUT] ##1
		!irq_req_q || irq_vec_q != SRC_EP0_OUT)
		else $error("usb service left flag set");

	AST_SERIAL_SERVICE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		service_hit && irq_vec_q == SRC_SERIAL && !set_evt[SRC_SERIAL] |=> !req_flag_q[SRC_SERIAL])
		else $error("serial service left flag set");

	AST_GROUP_SET: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		|timer_a_match_in |=> req_flag_q[SRC_GROUP] && |timer_a_match_flag_q)
		else $error("group flag not set by member");

	AST_GROUP_KEEPS_MEMBERS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		service_hit && irq_vec_q == SRC_GROUP && !(|timer_p_match_clr_in) && !(|timer_a_match_clr_in)
		|=> timer_p_match_flag_q == ($past(timer_p_match_flag_q) | $past(timer_p_match_in)))
		else $error("group service disturbed member flags");

	AST_TIMER_CALL: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		$rose(irq_req_q) && irq_vec_q == SRC_GROUP |-> $past(group_irq_en_in && group_member_live &&
		global_irq_en_q && !stack_full_in))
		else $error("group call without enables");

	AST_FLAG_HOLDS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		req_flag_q[SRC_LVD] && !req_flag_clr_in[SRC_LVD] && !(service_hit && irq_vec_q == SRC_LVD)
		|=> req_flag_q[SRC_LVD])
		else $error("flag dropped without service or clear");

	AST_RETURN_SETS_GIE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		return_from_interrupt_in |=> global_irq_en_q)
		else $error("return from interrupt did not set global enable");

	AST_PRIORITY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		irq_req_q |-> (($past(pending) >> irq_vec_q) & NUM_SRC'(1'b1)) == NUM_SRC'(1'b1) &&
		($past(pending) & ((NUM_SRC'(1'b1) << irq_vec_q) - NUM_SRC'(1'b1))) == '0)
		else $error("vector is not the highest pending source");
endmodule

/* File: hdl/mis_pkg.sv */
package mis_pkg;
	// ****************************************
	// source numbering and widths
	// ****************************************
	localparam int NUM_SRC = 9;
	localparam int VEC_W = 4;
	localparam int NUM_TMR = 2;
	localparam int NUM_EXT = 2;
	localparam int EP_W = 4;
	// index order is also the service priority, lowest index first
	localparam logic [VEC_W-1:0] SRC_EXT0 = 4'h0;
	localparam logic [VEC_W-1:0] SRC_EXT1 = 4'h1;
	localparam logic [VEC_W-1:0] SRC_USB = 4'h2;
	localparam logic [VEC_W-1:0] SRC_SETUP = 4'h3;
	localparam logic [VEC_W-1:0] SRC_EP0_IN = 4'h4;
	localparam logic [VEC_W-1:0] SRC_EP0_OUT = 4'h5;
	localparam logic [VEC_W-1:0] SRC_GROUP = 4'h6;
	localparam logic [VEC_W-1:0] SRC_SERIAL = 4'h7;
	localparam logic [VEC_W-1:0] SRC_LVD = 4'h8;
	// ****************************************
	// edge select field codes
	// ****************************************
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [3:0] EDGE_SEL_RST = 4'h0;
	// edges after reset release before prev_q holds a synchronised level
	localparam logic [1:0] SETTLE_CNT = 2'h3;
	// ****************************************
	// token kinds and reset values
	// ****************************************
	localparam logic [1:0] TOKEN_SETUP = 2'h1;
	localparam logic [1:0] TOKEN_IN = 2'h2;
	localparam logic [1:0] TOKEN_OUT = 2'h3;
	localparam logic [EP_W-1:0] EP_ZERO = 4'h0;
	localparam logic FLAG_RST = 1'b0;
	localparam logic GIE_RST = 1'b0;
endpackage

/* File: testbench/mcu_interrupt_sources_bench.sv */
`timescale 1ns/100ps
module mcu_interrupt_sources_bench;
	import mis_pkg::*;
	logic clk_sys_in = 1'b0, reset_n_in = 1'b0, edge_sel_wr_in = 1'b0, global_irq_en_set_in = 1'b0;
	logic global_irq_en_clr_in = 1'b0, usb_engine_irq_en_in = 1'b0, setup_token_irq_en_in = 1'b0;
	logic ep0_in_irq_en_in = 1'b0, ep0_out_irq_en_in = 1'b0, group_irq_en_in = 1'b0;
	logic serial_if_irq_en_in = 1'b0, low_volt_irq_en_in = 1'b0, usb_ep_access_in = 1'b0;
	logic serial_if_byte_done_in = 1'b0, low_voltage_detector_in = 1'b0, stack_full_in = 1'b0;
	logic return_from_interrupt_in = 1'b0, irq_ack_in, irq_req_out, global_irq_en_out, ack_en = 1'b0;
	logic [1:0] ext_pin_in = 2'h0, ext_pin_is_input_in = 2'h0, pull_high_sel_in = 2'h0, ext_pin_irq_en_in = 2'h0;
	logic [1:0] timer_p_match_en_in = 2'h0, timer_a_match_en_in = 2'h0, timer_p_match_clr_in = 2'h0;
	logic [1:0] timer_a_match_clr_in = 2'h0, timer_p_match_in = 2'h0, timer_a_match_in = 2'h0;
	logic [1:0] usb_token_kind_in = 2'h0, pull_high_en_out, timer_p_match_flag_out, timer_a_match_flag_out;
	logic [3:0] edge_sel_data_in = 4'h0, usb_ep_num_in = 4'h0, ext_edge_select_reg_out, irq_vector_out;
	logic [3:0] ack_wait = 4'h0, taken_vec;
	logic [7:0] taken_cnt;
	logic [8:0] req_flag_clr_in = 9'h000, req_flag_out, exp_flags;
	int miscompares = 0, tests_run = 0, cyc = 0;
	mis_irq_ctrl DUT (.clk_sys_in, .reset_n_in, .ext_pin_in, .ext_pin_is_input_in, .pull_high_sel_in,
		.pull_high_en_out, .edge_sel_wr_in, .edge_sel_data_in, .ext_edge_select_reg_out, .global_irq_en_set_in,
		.global_irq_en_clr_in, .global_irq_en_out, .ext_pin_irq_en_in, .usb_engine_irq_en_in,
		.setup_token_irq_en_in, .ep0_in_irq_en_in, .ep0_out_irq_en_in, .group_irq_en_in, .serial_if_irq_en_in,
		.low_volt_irq_en_in, .timer_p_match_en_in, .timer_a_match_en_in, .req_flag_clr_in, .req_flag_out,
		.timer_p_match_clr_in, .timer_a_match_clr_in, .timer_p_match_flag_out, .timer_a_match_flag_out,
		.usb_ep_access_in, .usb_ep_num_in, .usb_token_kind_in, .serial_if_byte_done_in, .low_voltage_detector_in,
		.timer_p_match_in, .timer_a_match_in, .stack_full_in, .irq_ack_in, .return_from_interrupt_in,
		.irq_req_out, .irq_vector_out);
	mis_core_model core (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .irq_req_in(irq_req_out),
		.irq_vector_in(irq_vector_out), .ack_en_in(ack_en), .ack_wait_in(ack_wait), .irq_ack_out(irq_ack_in),
		.taken_vec_out(taken_vec), .taken_cnt_out(taken_cnt));
	// ****************************************
	// clock, timeout and shared tasks
	// ****************************************
	initial begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			$display("mismatch at %0t: timeout", $time);
			wrap_up();
		end
	end
	task automatic tick();
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic serve(input logic [3:0] idx);
		logic [7:0] seen;
		seen = taken_cnt;
		for (int n = 0; n < 40 && taken_cnt === seen; n++) tick();
		chk(16'(taken_vec), 16'(idx), "vector taken");
		chk(16'(global_irq_en_out), 16'h0000, "global enable after service");
		chk(16'(req_flag_out[idx]), 16'h0000, "flag after service");
		return_from_interrupt_in = 1'b1;
		tick();
		return_from_interrupt_in = 1'b0;
		tick();
		chk(16'(global_irq_en_out), 16'h0001, "global enable after return");
	endtask
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_sys_in);
		#1 reset_n_in = 1'b1;
		tick();
		chk(16'(ext_edge_select_reg_out), 16'(EDGE_SEL_RST), "edge field reset");
		chk(16'({global_irq_en_out, irq_req_out, req_flag_out}), 16'h0000, "flags reset");
		pull_high_sel_in = 2'h2;
		#1 chk(16'(pull_high_en_out), 16'h0002, "pull-high kept");
		ext_pin_is_input_in = 2'h3;
		for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) begin
			edge_sel_data_in = 4'(m << (2 * p));
			edge_sel_wr_in = 1'b1;
			tick();
			edge_sel_wr_in = 1'b0;
			tick();
			chk(16'(ext_edge_select_reg_out), 16'(edge_sel_data_in), "edge field");
			ext_pin_in[p] = 1'b1;
			repeat (5) tick();
			chk(16'(req_flag_out[p]), 16'(m[0]), "rising edge flag");
			req_flag_clr_in[p] = 1'b1;
			tick();
			req_flag_clr_in = 9'h000;
			ext_pin_in[p] = 1'b0;
			repeat (5) tick();
			chk(16'(req_flag_out[p]), 16'(m[1]), "falling edge flag");
			req_flag_clr_in[p] = 1'b1;
			tick();
			req_flag_clr_in = 9'h000;
		end
		// pin not yet an input: its edges must be ignored
		edge_sel_data_in = 4'hf;
		edge_sel_wr_in = 1'b1;
		ext_pin_is_input_in = 2'h0;
		tick();
		edge_sel_wr_in = 1'b0;
		ext_pin_in = 2'h3;
		repeat (5) tick();
		chk(16'(req_flag_out), 16'h0000, "edge on output pin");
		ext_pin_is_input_in = 2'h3;
		ext_pin_in = 2'h0;
		repeat (5) tick();
		exp_flags = 9'h003;
		usb_ep_num_in = 4'h1;
		usb_token_kind_in = TOKEN_IN;
		usb_ep_access_in = 1'b1;
		tick();
		usb_ep_access_in = 1'b0;
		tick();
		exp_flags[SRC_USB] = 1'b1;
		chk(16'(req_flag_out), 16'(exp_flags), "endpoint one access");
		for (int k = 1; k < 4; k++) begin
			usb_ep_num_in = EP_ZERO;
			usb_token_kind_in = 2'(k);
			usb_ep_access_in = 1'b1;
			tick();
			usb_ep_access_in = 1'b0;
			tick();
			exp_flags[2 + k] = 1'b1;
			chk(16'(req_flag_out), 16'(exp_flags), "endpoint zero token");
		end
		serial_if_byte_done_in = 1'b1;
		tick();
		serial_if_byte_done_in = 1'b0;
		low_voltage_detector_in = 1'b1;
		timer_a_match_in = 2'h2;
		timer_p_match_in = 2'h1;
		tick();
		timer_a_match_in = 2'h0;
		timer_p_match_in = 2'h0;
		chk(16'({timer_a_match_flag_out, timer_p_match_flag_out}), 16'h0009, "timer flags");
		timer_p_match_clr_in = 2'h1;
		tick();
		timer_p_match_clr_in = 2'h0;
		repeat (4) tick();
		chk(16'(timer_p_match_flag_out), 16'h0000, "timer flag cleared");
		chk(16'(req_flag_out), 16'h01ff, "all sources flagged");
		global_irq_en_set_in = 1'b1;
		tick();
		global_irq_en_set_in = 1'b0;
		repeat (4) tick();
		chk(16'({irq_req_out, req_flag_out}), 16'h01ff, "disabled flags held");
		// every enable on but the stack is full: no call may be made
		{ext_pin_irq_en_in, usb_engine_irq_en_in, setup_token_irq_en_in, ep0_in_irq_en_in} = 5'h1f;
		{ep0_out_irq_en_in, group_irq_en_in, serial_if_irq_en_in, low_volt_irq_en_in} = 4'hf;
		{timer_p_match_en_in, timer_a_match_en_in} = 4'hf;
		stack_full_in = 1'b1;
		repeat (4) tick();
		chk(16'(irq_req_out), 16'h0000, "stack full");
		// software clear of the global enable must hold every call off
		global_irq_en_clr_in = 1'b1;
		tick();
		global_irq_en_clr_in = 1'b0;
		stack_full_in = 1'b0;
		repeat (3) tick();
		chk(16'({irq_req_out, global_irq_en_out}), 16'h0000, "global enable cleared");
		global_irq_en_set_in = 1'b1;
		ack_en = 1'b1;
		tick();
		global_irq_en_set_in = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			ack_wait = i[0] ? 4'h3 : 4'h0;
			serve(4'(i));
		end
		ack_en = 1'b0;
		tick();
		chk(16'({irq_req_out, timer_a_match_flag_out, req_flag_out}), 16'h0400, "members kept");
		timer_a_match_clr_in = 2'h3;
		timer_p_match_en_in = 2'h0;
		timer_p_match_in = 2'h2;
		tick();
		timer_a_match_clr_in = 2'h0;
		timer_p_match_in = 2'h0;
		repeat (3) tick();
		chk(16'({irq_req_out, req_flag_out}), 16'h0040, "member not enabled");
		timer_p_match_en_in = 2'h2;
		repeat (2) tick();
		chk(16'({irq_req_out, irq_vector_out}), 16'h0016, "member enabled");
		wrap_up();
	end
endmodule

/* File: testbench/mis_core_model.sv */
`timescale 1ns/100ps
module mis_core_model (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// request from the controller
	input wire logic irq_req_in,
	input wire logic [mis_pkg::VEC_W-1:0] irq_vector_in,
	// behaviour set by the bench
	input wire logic ack_en_in,
	input wire logic [3:0] ack_wait_in,
	// answer and record
	output logic irq_ack_out,
	output logic [mis_pkg::VEC_W-1:0] taken_vec_out,
	output logic [7:0] taken_cnt_out
);
	import mis_pkg::*;
	logic [3:0] wait_q;
	// ****************************************
	// vector fetch
	// ****************************************
	// a slow core lets a request stand for several cycles, so vector changes in the meantime are seen
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_q <= 4'h0;
			irq_ack_out <= 1'b0;
			taken_vec_out <= 4'h0;
			taken_cnt_out <= 8'h00;
		end else if (irq_ack_out) begin
			taken_vec_out <= irq_vector_in;
			taken_cnt_out <= taken_cnt_out + 8'h01;
			wait_q <= 4'h0;
			irq_ack_out <= #1 1'b0;
		end else if (irq_req_in && ack_en_in) begin
			if (wait_q >= ack_wait_in) begin
				irq_ack_out <= #1 1'b1;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end else begin
			wait_q <= 4'h0;
		end
	end
endmodule
